// ---- core/tec_timer.sv ----
// Design: three 8-bit timer/event counter channels with compare match, square-wave output on channel 2
`timescale 1ns/10ps
module tec_timer #(
   parameter int CNT_W = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // CPU register port, byte wide
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   output logic cpu_hit,
   // Count sources
   input wire logic ext_event_input_0,
   input wire logic ext_event_input_1,
   input wire logic subsys_clk_tick,
   // Events and pin
   output logic [2:0] match_interrupt_request,
   output logic ch2_timer_output_pin,
   output logic ch2_output_gate
);
   import tec_pkg::*;

   // ************************************************************
   // Storage
   // ************************************************************
   logic [7:0] ctrl_ff [3];
   logic [CNT_W-1:0] cmp_ff [3];
   logic [CNT_W-1:0] cnt_ff [3];
   logic [TEC_PRESCALE_W-1:0] pre_ff;
   logic [1:0] ext_ff;
   logic [2:0] irq_ff;
   logic tout_ff;
   logic [7:0] rdata_ff;

   // Prescaler tap pulse: one cycle while the low bits of the free counter are all ones
   function automatic logic tap(input logic [TEC_PRESCALE_W-1:0] p, input int lg);
      logic [TEC_PRESCALE_W-1:0] m;
      m = TEC_PRESCALE_W'((1 << lg) - 1);
      tap = ((p & m) == m);
   endfunction

   // Edge pick for event channels
   function automatic logic edge_sel(input logic [1:0] sel, input logic now, input logic old,
                                     input logic fast, input logic slow);
      case (sel)
         TEC_SEL_FAST: edge_sel = fast;
         TEC_SEL_SLOW: edge_sel = slow;
         TEC_SEL_RISE: edge_sel = now & ~old;
         default: edge_sel = ~now & old;
      endcase
   endfunction

   // ************************************************************
   // Address decode
   // ************************************************************
   // Each channel owns four bytes: spare, compare, counter, control
   wire [2:0] hit_ctrl;
   wire [2:0] hit_cmp;
   wire [2:0] hit_cnt;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_dec
         localparam logic [15:0] OFS = 16'(g) * TEC_CH_STRIDE;
         assign hit_ctrl[g] = (cpu_addr == TEC_CH0_CTRL_ADDR + OFS);
         assign hit_cmp[g] = (cpu_addr == TEC_CMP_BASE_ADDR + OFS);
         assign hit_cnt[g] = (cpu_addr == TEC_CNT_BASE_ADDR + OFS);
      end
   endgenerate
   // Any mapped byte
   assign cpu_hit = |{hit_ctrl, hit_cmp, hit_cnt};

   // ************************************************************
   // Count clock selection
   // ************************************************************
   wire [2:0] tick;
   wire [1:0] sel0 = ctrl_ff[0][TEC_SEL_HI:TEC_SEL_LO];
   wire [1:0] sel1 = ctrl_ff[1][TEC_SEL_HI:TEC_SEL_LO];
   wire [1:0] sel2 = ctrl_ff[2][TEC_SEL_HI:TEC_SEL_LO];
   // Channel 0 taps and input 0 edges
   assign tick[0] = edge_sel(sel0, ext_event_input_0, ext_ff[0], tap(pre_ff, TEC_CH0_FAST_LOG2),
                             tap(pre_ff, TEC_CH0_SLOW_LOG2));
   // Channel 1 taps and input 1 edges
   assign tick[1] = edge_sel(sel1, ext_event_input_1, ext_ff[1], tap(pre_ff, TEC_CH1_FAST_LOG2),
                             tap(pre_ff, TEC_CH1_SLOW_LOG2));
   // Channel 2 taps or subsystem tick; prohibited code counts nothing
   assign tick[2] = (sel2 == TEC_SEL_FAST) ? tap(pre_ff, TEC_CH2_FAST_LOG2) :
                    (sel2 == TEC_SEL_SLOW) ? tap(pre_ff, TEC_CH2_SLOW_LOG2) :
                    (sel2 == TEC_SEL_RISE) ? subsys_clk_tick : 1'b0;

   // Per-channel next counter and match
   wire [2:0] run;
   wire [2:0] match;
   logic [CNT_W-1:0] nxt_cnt [3];
   generate
      for (g = 0; g < 3; g++) begin : g_ch
         assign run[g] = ctrl_ff[g][TEC_RUN_BIT];
         // Match taken on a count clock while counter equals compare
         assign match[g] = run[g] & tick[g] & (cnt_ff[g] == cmp_ff[g]);
         // Stop clears, match wraps to zero, else count up
         assign nxt_cnt[g] = !run[g] ? CNT_W'(TEC_CNT_RESET) :
                             match[g] ? CNT_W'(TEC_CNT_RESET) :
                             tick[g] ? cnt_ff[g] + CNT_W'(1) : cnt_ff[g];
      end
   endgenerate

   // Read mux, unused control bits masked off
   logic [7:0] nxt_rdata;
   always_comb begin
      nxt_rdata = 8'h00;
      for (int i = 0; i < 3; i++) begin
         if (hit_ctrl[i]) begin
            nxt_rdata = ctrl_ff[i] & ((i == 2) ? TEC_CTRL_MASK2 : TEC_CTRL_MASK01);
         end
         if (hit_cmp[i]) begin
            nxt_rdata = 8'(cmp_ff[i]);
         end
         if (hit_cnt[i]) begin
            nxt_rdata = 8'(cnt_ff[i]);
         end
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   // Free-running prescaler and edge history
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pre_ff <= '0;
         ext_ff <= 2'h0;
      end else begin
         pre_ff <= pre_ff + TEC_PRESCALE_ONE;
         ext_ff <= {ext_event_input_1, ext_event_input_0};
      end
   end

   // Control registers, byte writes; bit operations arrive as byte writes
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (rst) begin
            ctrl_ff[i] <= TEC_CTRL_RESET;
         end else if (cpu_wr && hit_ctrl[i]) begin
            ctrl_ff[i] <= cpu_wdata & ((i == 2) ? TEC_CTRL_MASK2 : TEC_CTRL_MASK01);
         end
      end
   end

   // Compare registers, deliberately without reset
   // Compare content is unknown until software writes it
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (cpu_wr && hit_cmp[i]) begin
            cmp_ff[i] <= cpu_wdata[CNT_W-1:0];
         end
      end
   end

   // Counters; writes to counter addresses are ignored
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (rst) begin
            cnt_ff[i] <= CNT_W'(TEC_CNT_RESET);
         end else begin
            cnt_ff[i] <= nxt_cnt[i];
         end
      end
   end

   // Requests, square wave and read data
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_ff <= 3'h0;
         tout_ff <= 1'b0;
         rdata_ff <= 8'h00;
      end else begin
         irq_ff <= match;
         if (!(run[2] && ctrl_ff[2][TEC_GATE_BIT])) begin
            tout_ff <= 1'b0;
         end else if (match[2]) begin
            tout_ff <= ~tout_ff;
         end
         rdata_ff <= cpu_rd ? nxt_rdata : rdata_ff;
      end
   end

   assign match_interrupt_request = irq_ff;
   assign ch2_output_gate = ctrl_ff[2][TEC_GATE_BIT];
   assign ch2_timer_output_pin = tout_ff;
   assign cpu_rdata = rdata_ff;

   // ************************************************************
   // Checks
   // ************************************************************
   // A count clock arriving while a running counter sits on its compare value
   sequence s_ch0_match;
      run[0] && tick[0] && cnt_ff[0] == cmp_ff[0];
   endsequence

   sequence s_ch1_match;
      run[1] && tick[1] && cnt_ff[1] == cmp_ff[1];
   endsequence

   sequence s_ch2_match;
      run[2] && tick[2] && cnt_ff[2] == cmp_ff[2];
   endsequence

   // Channel 0 cycle with no match point
   sequence s_ch0_quiet;
      !(run[0] && tick[0] && cnt_ff[0] == cmp_ff[0]);
   endsequence

   // Channel 2 output not handed to a running timer
   sequence s_ch2_idle;
      !(run[2] && ctrl_ff[2][TEC_GATE_BIT]);
   endsequence

   // A match raises only its own channel's request, one cycle later
   ch0_match_irq_a: assert property (@(posedge core_clk) disable iff (rst)
      s_ch0_match |=> match_interrupt_request[0]) else $error("ch0 match without request");
   ch1_match_irq_a: assert property (@(posedge core_clk) disable iff (rst)
      s_ch1_match |=> match_interrupt_request[1]) else $error("ch1 match without request");
   ch2_match_irq_a: assert property (@(posedge core_clk) disable iff (rst)
      s_ch2_match |=> match_interrupt_request[2]) else $error("ch2 match without request");
   ch0_quiet_irq_a: assert property (@(posedge core_clk) disable iff (rst)
      s_ch0_quiet |=> !match_interrupt_request[0]) else $error("ch0 request without match");

   // Match point wraps the counter to zero
   ch0_wrap_a: assert property (@(posedge core_clk) disable iff (rst)
      s_ch0_match |=> cnt_ff[0] == 8'h00) else $error("ch0 counter not cleared on match");
   ch2_wrap_a: assert property (@(posedge core_clk) disable iff (rst)
      s_ch2_match |=> cnt_ff[2] == 8'h00) else $error("ch2 counter not cleared on match");

   // Stopped counters sit at zero
   stop_clear_a: assert property (@(posedge core_clk) disable iff (rst)
      !ctrl_ff[1][TEC_RUN_BIT] |=> cnt_ff[1] == 8'h00) else $error("stopped counter not zero");
   ch0_stop_clear_a: assert property (@(posedge core_clk) disable iff (rst)
      !ctrl_ff[0][TEC_RUN_BIT] |=> cnt_ff[0] == 8'h00) else $error("stopped ch0 counter not zero");
   ch2_stop_clear_a: assert property (@(posedge core_clk) disable iff (rst)
      !ctrl_ff[2][TEC_RUN_BIT] |=> cnt_ff[2] == 8'h00) else $error("stopped ch2 counter not zero");

   // Counting steps by one on each count clock
   ch1_count_a: assert property (@(posedge core_clk) disable iff (rst)
      run[1] && tick[1] && cnt_ff[1] != cmp_ff[1] |=> cnt_ff[1] == $past(cnt_ff[1]) + 8'h01)
      else $error("ch1 did not step");

   // Only the selected tap or edge moves a running counter
   ch2_fast_a: assert property (@(posedge core_clk) disable iff (rst)
      run[2] && sel2 == TEC_SEL_FAST && pre_ff[2:0] != 3'h7 |=> $stable(cnt_ff[2]))
      else $error("ch2 stepped off its tap");
   ch0_slow_a: assert property (@(posedge core_clk) disable iff (rst)
      run[0] && sel0 == TEC_SEL_SLOW && pre_ff[8:0] != 9'h1FF |=> $stable(cnt_ff[0]))
      else $error("ch0 stepped off its slow tap");
   ch1_fast_a: assert property (@(posedge core_clk) disable iff (rst)
      run[1] && sel1 == TEC_SEL_FAST && pre_ff[3:0] != 4'hF |=> $stable(cnt_ff[1]))
      else $error("ch1 stepped off its fast tap");
   ch0_rise_a: assert property (@(posedge core_clk) disable iff (rst)
      run[0] && sel0 == TEC_SEL_RISE && !(ext_event_input_0 && !ext_ff[0]) |=> $stable(cnt_ff[0]))
      else $error("ch0 stepped without rising edge");
   ch1_fall_a: assert property (@(posedge core_clk) disable iff (rst)
      run[1] && sel1 == TEC_SEL_FALL && !(!ext_event_input_1 && ext_ff[1]) |=> $stable(cnt_ff[1]))
      else $error("ch1 stepped without falling edge");
   ch2_sub_a: assert property (@(posedge core_clk) disable iff (rst)
      run[2] && sel2 == TEC_SEL_RISE && !subsys_clk_tick |=> $stable(cnt_ff[2]))
      else $error("ch2 stepped without subsystem tick");

   // Square wave toggles on match and rests low while run or gate is off
   tout_toggle_a: assert property (@(posedge core_clk) disable iff (rst)
      run[2] && ctrl_ff[2][TEC_GATE_BIT] && match[2] |=> ch2_timer_output_pin != $past(ch2_timer_output_pin))
      else $error("output did not toggle");
   tout_idle_a: assert property (@(posedge core_clk) disable iff (rst)
      s_ch2_idle |=> !ch2_timer_output_pin) else $error("output not low while disabled");

   // Unused control bits never hold a one
   ctrl_zero_a: assert property (@(posedge core_clk) disable iff (rst)
      ctrl_ff[0][6:3] == 4'h0 && ctrl_ff[0][0] == 1'b0) else $error("unused control bits set");
   ctrl1_zero_a: assert property (@(posedge core_clk) disable iff (rst)
      ctrl_ff[1][6:3] == 4'h0 && ctrl_ff[1][0] == 1'b0) else $error("unused ch1 control bits set");
   ctrl2_zero_a: assert property (@(posedge core_clk) disable iff (rst)
      ctrl_ff[2][6:3] == 4'h0) else $error("unused ch2 control bits set");
endmodule

// ---- include/tec_pkg.sv ----
// Package: register map, field layout, reset values and prescaler taps for the triple 8-bit timer
package tec_pkg;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [15:0] TEC_CH0_CTRL_ADDR = 16'hFF53;
   localparam logic [15:0] TEC_CH1_CTRL_ADDR = 16'hFF57;
   localparam logic [15:0] TEC_CH2_CTRL_ADDR = 16'hFF5B;
   localparam logic [15:0] TEC_CMP_BASE_ADDR = 16'hFF51;
   localparam logic [15:0] TEC_CNT_BASE_ADDR = 16'hFF52;
   localparam logic [15:0] TEC_CH_STRIDE = 16'h0004;
   // ************************************************************
   // Control register fields
   // ************************************************************
   localparam int TEC_RUN_BIT = 7;
   localparam int TEC_SEL_HI = 2;
   localparam int TEC_SEL_LO = 1;
   localparam int TEC_GATE_BIT = 0;
   localparam logic [7:0] TEC_CTRL_RESET = 8'h00;
   localparam logic [7:0] TEC_CTRL_MASK01 = 8'h86;
   localparam logic [7:0] TEC_CTRL_MASK2 = 8'h87;
   localparam logic [7:0] TEC_CNT_RESET = 8'h00;
   // ************************************************************
   // Clock selects
   // ************************************************************
   localparam logic [1:0] TEC_SEL_FAST = 2'h0;
   localparam logic [1:0] TEC_SEL_SLOW = 2'h1;
   localparam logic [1:0] TEC_SEL_RISE = 2'h2;
   localparam logic [1:0] TEC_SEL_FALL = 2'h3;
   localparam int TEC_CH0_FAST_LOG2 = 6;
   localparam int TEC_CH0_SLOW_LOG2 = 9;
   localparam int TEC_CH1_FAST_LOG2 = 4;
   localparam int TEC_CH1_SLOW_LOG2 = 8;
   localparam int TEC_CH2_FAST_LOG2 = 3;
   localparam int TEC_CH2_SLOW_LOG2 = 7;
   localparam int TEC_PRESCALE_W = 9;
   localparam logic [TEC_PRESCALE_W-1:0] TEC_PRESCALE_ONE = 9'h001;
endpackage

// ---- dv/test_triple_8bit_timer_event_counter.sv ----
// Testbench: registers, event counting, prescaler intervals and square wave of the triple timer
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
   $display("mismatch %s exp %h got %h", nm, exp, got); end end
module test_triple_8bit_timer_event_counter;
   import tec_pkg::*;
   // ****************************************
   // Signals, clock and design
   // ****************************************
   logic core_clk = 0, rst = 1, cpu_wr = 0, cpu_rd = 0, ev0 = 0, ev1 = 0, tick = 0;
   logic [15:0] cpu_addr = 16'h0000;
   logic [7:0] cpu_wdata = 8'h00, cpu_rdata, d;
   logic cpu_hit, ch2_pin, ch2_gate;
   logic [2:0] irq;
   integer seed = 32'h4DC6F6E3;
   int error_cnt = 0, checked = 0, irq_cnt[3], n, c, cyc;
   int lg[6] = '{TEC_CH0_FAST_LOG2, TEC_CH1_FAST_LOG2, TEC_CH2_FAST_LOG2,
      TEC_CH0_SLOW_LOG2, TEC_CH1_SLOW_LOG2, TEC_CH2_SLOW_LOG2};
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   tec_timer dut_u (.core_clk(core_clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
      .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit), .ext_event_input_0(ev0),
      .ext_event_input_1(ev1), .subsys_clk_tick(tick), .match_interrupt_request(irq),
      .ch2_timer_output_pin(ch2_pin), .ch2_output_gate(ch2_gate));
   // Match pulse tally per channel
   always @(posedge core_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (irq[i] === 1'b1) begin
            irq_cnt[i]++;
         end
      end
   end
   // ****************************************
   // Bus, event and wait tasks
   // ****************************************
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge core_clk) #1;
      cpu_addr = a;
      cpu_wdata = v;
      cpu_wr = 1;
      @(posedge core_clk) #1;
      cpu_wr = 0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string nm);
      @(posedge core_clk) #1;
      cpu_addr = a;
      cpu_rd = 1;
      @(posedge core_clk) #1;
      cpu_rd = 0;
      `CHK(nm, exp, cpu_rdata)
   endtask
   // One counted edge, then back to idle
   task automatic ev_edge(input int ch);
      repeat (2) begin
         @(posedge core_clk) #1;
         ev0 ^= (ch == 0);
         ev1 ^= (ch == 1);
         repeat (3) @(posedge core_clk);
      end
   endtask
   task automatic wait_irq(input int ch, output int cnt);
      cnt = 0;
      do begin
         @(posedge core_clk) #1;
         cnt++;
      end while (irq[ch] !== 1'b1 && cnt < 4000);
   endtask
   // Readback of a control byte with unused bits dropped
   function automatic logic [7:0] ctrl_exp(input int ch, input logic [7:0] v);
      return v & ((ch == 2) ? TEC_CTRL_MASK2 : TEC_CTRL_MASK01);
   endfunction
   // Main clock cycles between two requests for a compare value on tap 2**lg2
   function automatic int gap_exp(input int cmp_val, input int lg2);
      return (cmp_val + 1) << lg2;
   endfunction
   task automatic complete_run();
      $display("counts: checked %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (16) @(posedge core_clk);
      #1 rst = 0;
      // Reset values, read-only counters, unmapped place
      for (int k = 0; k < 3; k++) begin
         rd(TEC_CH0_CTRL_ADDR + 16'(4 * k), TEC_CTRL_RESET, "ctrl");
         wr(TEC_CNT_BASE_ADDR + 16'(4 * k), 8'h5A);
         rd(TEC_CNT_BASE_ADDR + 16'(4 * k), TEC_CNT_RESET, "count");
         `CHK("hit", 1'b1, cpu_hit)
      end
      rd(16'hFF5F, 8'h00, "unmapped");
      `CHK("hit", 1'b0, cpu_hit)
      `CHK("pin", 1'b0, ch2_pin)
      $display("test reset done");
      // Prescaler taps: interval, readback masking, stop clears
      for (int i = 0; i < 6; i++) begin
         c = i % 3;
         // Channel 2 fast tap also runs the top compare value
         n = (i == 2) ? 255 : ($random(seed) & 3);
         d = (8'($random(seed)) & 8'h79) | 8'(i / 3 << 1);
         wr(TEC_CMP_BASE_ADDR + 16'(4 * c), 8'(n));
         rd(TEC_CMP_BASE_ADDR + 16'(4 * c), 8'(n), "compare");
         wr(TEC_CH0_CTRL_ADDR + 16'(4 * c), d);
         wr(TEC_CH0_CTRL_ADDR + 16'(4 * c), d | 8'h80);
         rd(TEC_CH0_CTRL_ADDR + 16'(4 * c), ctrl_exp(c, d | 8'h80), "ctrl");
         if (c == 2) `CHK("gate", d[0], ch2_gate)
         wait_irq(c, cyc);
         wait_irq(c, cyc);
         `CHK("interval", gap_exp(n, lg[i]), cyc)
         wr(TEC_CH0_CTRL_ADDR + 16'(4 * c), d);
         rd(TEC_CNT_BASE_ADDR + 16'(4 * c), 8'h00, "stopped");
      end
      $display("test prescaler done");
      // External edges, both polarities, both channels
      for (int j = 0; j < 4; j++) begin
         c = j / 2;
         n = 1 + ($random(seed) & 3);
         ev0 = j[0];
         ev1 = j[0];
         wr(TEC_CMP_BASE_ADDR + 16'(4 * c), 8'(n));
         wr(TEC_CH0_CTRL_ADDR + 16'(4 * c), 8'(4 + 2 * j[0]));
         wr(TEC_CH0_CTRL_ADDR + 16'(4 * c), 8'(8'h84 + 2 * j[0]));
         irq_cnt[c] = 0;
         for (int k = 1; k <= n + 1; k++) begin
            ev_edge(c);
            rd(TEC_CNT_BASE_ADDR + 16'(4 * c), 8'(k % (n + 1)), "events");
         end
         `CHK("matches", 1, irq_cnt[c])
         wr(TEC_CH0_CTRL_ADDR + 16'(4 * c), 8'h00);
      end
      $display("test events done");
      // Subsystem ticks on channel 2 with square wave
      n = $random(seed) & 3;
      wr(TEC_CMP_BASE_ADDR + 16'h0008, 8'(n));
      wr(TEC_CH2_CTRL_ADDR, 8'h05);
      `CHK("pin", 1'b0, ch2_pin)
      wr(TEC_CH2_CTRL_ADDR, 8'h85);
      irq_cnt[2] = 0;
      for (int k = 1; k <= 2 * n + 2; k++) begin
         @(posedge core_clk) #1;
         tick = 1;
         @(posedge core_clk) #1;
         tick = 0;
         repeat (3) @(posedge core_clk);
         `CHK("wave", 1'((k / (n + 1)) % 2), ch2_pin)
      end
      `CHK("matches", 2, irq_cnt[2])
      wr(TEC_CH2_CTRL_ADDR, 8'h00);
      `CHK("gate", 1'b0, ch2_gate)
      `CHK("pin", 1'b0, ch2_pin)
      $display("test square wave done");
      complete_run();
   end
   // Watchdog against a hung wait
   initial begin
      #(50 * 40000);
      error_cnt++;
      complete_run();
   end
endmodule
